// [core/ssc_stage_config.sv]
/*
 * Per-stage sense configuration store and decode for the conversion sequencer.
 * Holds routing, offset and sensitivity words for every stage and presents the decoded
 * settings of the stage the sequencer selects. Assumes a register port already framed
 * by the serial interface into single-cycle word reads and writes.
 */
// Summary of operation
// R1 - routing code: off, negative, positive, bias
// R2 - inputs 7..13 packed two bits each
// R3 - bit 14 set turns negative offset off
// R4 - bit 15 set turns positive offset off
// R5 - negative offset magnitude 0.16 pF per count
// R6 - bit 7 moves negative offset to positive
// R7 - positive offset magnitude 0.16 pF per count
// R8 - bit 15 moves positive offset to negative
// R9 - negative threshold from sixteen-level table
// R10 - positive threshold uses same table
// R11 - negative peak level 40 to 90 percent
// R12 - positive peak level uses same mapping
// R13 - host writes unused sensitivity bits zero
// R14 - host ties unused inputs to bias
// R15 - identical layout for twelve stages
// R16 - lower routing holds inputs 0..6
// R17 - host programs stages before relying on them
module ssc_stage_config #(
    parameter int STAGES = 12
) (
    input wire logic i_clk,
    input wire logic i_reset,
    input wire logic i_wr_en,
    input wire logic i_rd_en,
    input wire logic [9:0] i_addr,
    input wire logic [15:0] i_wdata,
    output logic [15:0] o_rdata,
    output logic o_rd_hit,
    input wire logic [3:0] i_stage_sel,
    output logic [13:0] o_to_pos,
    output logic [13:0] o_to_neg,
    output logic [13:0] o_to_bias,
    output logic o_negative_offset_en,
    output logic o_positive_offset_en,
    output logic [6:0] o_negative_offset_magnitude,
    output logic [6:0] o_positive_offset_magnitude,
    output logic [15:0] o_negative_offset_ff,
    output logic [15:0] o_positive_offset_ff,
    output logic o_negative_offset_steer,
    output logic o_positive_offset_steer,
    output logic [15:0] o_negative_threshold_fraction,
    output logic [15:0] o_positive_threshold_fraction,
    output logic [15:0] o_negative_peak_level,
    output logic [15:0] o_positive_peak_level
);
    localparam int NWORDS = STAGES * ssc_pkg::SSC_WORDS_PER_STAGE;

    typedef struct packed {
        logic [NWORDS-1:0][15:0] cfg;
        logic [15:0] rdata;
        logic rd_hit;
        logic [13:0] to_pos;
        logic [13:0] to_neg;
        logic [13:0] to_bias;
        logic neg_en;
        logic pos_en;
        logic [6:0] neg_mag;
        logic [6:0] pos_mag;
        logic [15:0] neg_ff;
        logic [15:0] pos_ff;
        logic neg_steer;
        logic pos_steer;
        logic [15:0] neg_thr;
        logic [15:0] pos_thr;
        logic [15:0] neg_pk;
        logic [15:0] pos_pk;
    } ssc_state_t;

    ssc_state_t st_r;
    ssc_state_t st_nxt;
    logic [27:0] route_codes;
    logic [13:0] dec_pos;
    logic [13:0] dec_neg;
    logic [13:0] dec_bias;
    logic [15:0] lower_w;
    logic [15:0] upper_w;
    logic [15:0] offset_w;
    logic [15:0] sens_w;

    // ---------------------------------------------------------------
    // selected stage words
    // ---------------------------------------------------------------
    // an out-of-range stage select reads as all zero, so every input stays off
    always_comb
    begin
        lower_w = 16'h0000;
        upper_w = 16'h0000;
        offset_w = 16'h0000;
        sens_w = 16'h0000;
        if (int'(i_stage_sel) < STAGES)
        begin
            lower_w = st_r.cfg[int'(i_stage_sel) * 4 + int'(ssc_pkg::SSC_OFS_LOWER_ROUTING)];
            upper_w = st_r.cfg[int'(i_stage_sel) * 4 + int'(ssc_pkg::SSC_OFS_UPPER_ROUTING)];
            offset_w = st_r.cfg[int'(i_stage_sel) * 4 + int'(ssc_pkg::SSC_OFS_OFFSET_CONTROL)];
            sens_w = st_r.cfg[int'(i_stage_sel) * 4 + int'(ssc_pkg::SSC_OFS_SENSITIVITY)]; // R15
        end
    end

    // ---------------------------------------------------------------
    // routing decoders, one per sense input
    // ---------------------------------------------------------------
    assign route_codes = {upper_w[13:0], lower_w[13:0]}; // R2 R16

    genvar gi;
    generate
        for (gi = 0; gi < 14; gi++)
        begin : g_route
            ssc_route_dec u_dec (
                .i_code(route_codes[2*gi +: 2]),
                .o_to_pos(dec_pos[gi]),
                .o_to_neg(dec_neg[gi]),
                .o_to_bias(dec_bias[gi])
            );
        end
    endgenerate

    // ---------------------------------------------------------------
    // next state
    // ---------------------------------------------------------------
    always_comb
    begin
        logic [9:0] rel;
        logic hit;
        int idx;
        logic [2:0] npk;
        logic [2:0] ppk;
        st_nxt = st_r;
        rel = i_addr - ssc_pkg::SSC_STAGE_BASE;
        // the offset and clamp words of each stage live elsewhere and decode as unmapped
        hit = (i_addr >= ssc_pkg::SSC_STAGE_BASE)
            && (rel < 10'(STAGES * ssc_pkg::SSC_STAGE_STRIDE)) && !rel[2];
        idx = int'(rel[9:3]) * ssc_pkg::SSC_WORDS_PER_STAGE + int'(rel[1:0]); // R15
        if (i_wr_en && hit)
        begin
            st_nxt.cfg[idx] = i_wdata;
        end
        st_nxt.rd_hit = i_rd_en && hit;
        st_nxt.rdata = (i_rd_en && hit) ? st_r.cfg[idx] : 16'h0000;

        st_nxt.to_pos = dec_pos; // R1
        st_nxt.to_neg = dec_neg; // R1
        st_nxt.to_bias = dec_bias; // R1
        st_nxt.neg_en = !upper_w[ssc_pkg::SSC_NEG_OFF_BIT]; // R3
        st_nxt.pos_en = !upper_w[ssc_pkg::SSC_POS_OFF_BIT]; // R4
        st_nxt.neg_mag = offset_w[ssc_pkg::SSC_NEG_MAG_LSB +: 7]; // R5
        st_nxt.pos_mag = offset_w[ssc_pkg::SSC_POS_MAG_LSB +: 7]; // R7
        st_nxt.neg_ff = 16'(offset_w[ssc_pkg::SSC_NEG_MAG_LSB +: 7]
            * ssc_pkg::SSC_OFFSET_FF_PER_LSB); // R5
        st_nxt.pos_ff = 16'(offset_w[ssc_pkg::SSC_POS_MAG_LSB +: 7]
            * ssc_pkg::SSC_OFFSET_FF_PER_LSB); // R7
        st_nxt.neg_steer = offset_w[ssc_pkg::SSC_NEG_STEER_BIT]; // R6
        st_nxt.pos_steer = offset_w[ssc_pkg::SSC_POS_STEER_BIT]; // R8
        st_nxt.neg_thr = ssc_pkg::SSC_THR_TABLE[sens_w[ssc_pkg::SSC_NEG_THR_LSB +: 4]]; // R9
        st_nxt.pos_thr = ssc_pkg::SSC_THR_TABLE[sens_w[ssc_pkg::SSC_POS_THR_LSB +: 4]]; // R10
        // codes 110 and 111 are undefined; held at the top level rather than wrapping
        npk = sens_w[ssc_pkg::SSC_NEG_PEAK_LSB +: 3];
        ppk = sens_w[ssc_pkg::SSC_POS_PEAK_LSB +: 3];
        if (npk > ssc_pkg::SSC_PEAK_MAX_CODE)
        begin
            npk = ssc_pkg::SSC_PEAK_MAX_CODE;
        end
        if (ppk > ssc_pkg::SSC_PEAK_MAX_CODE)
        begin
            ppk = ssc_pkg::SSC_PEAK_MAX_CODE;
        end
        st_nxt.neg_pk = 16'(ssc_pkg::SSC_PEAK_BASE + npk * ssc_pkg::SSC_PEAK_STEP); // R11
        st_nxt.pos_pk = 16'(ssc_pkg::SSC_PEAK_BASE + ppk * ssc_pkg::SSC_PEAK_STEP); // R12
    end

    // ---------------------------------------------------------------
    // state register
    // ---------------------------------------------------------------
    // words clear to zero (all inputs off) so nothing couples before software sets it up
    always_ff @(posedge i_clk)
    begin
        if (i_reset)
        begin
            st_r <= '0;
            st_r.cfg <= {NWORDS{ssc_pkg::SSC_RESET_WORD}};
            st_r.neg_en <= 1'b1;
            st_r.pos_en <= 1'b1;
            st_r.neg_thr <= ssc_pkg::SSC_THR_TABLE[0];
            st_r.pos_thr <= ssc_pkg::SSC_THR_TABLE[0];
            st_r.neg_pk <= ssc_pkg::SSC_PEAK_BASE;
            st_r.pos_pk <= ssc_pkg::SSC_PEAK_BASE;
        end
        else
        begin
            st_r <= st_nxt;
        end
    end

    // ---------------------------------------------------------------
    // outputs
    // ---------------------------------------------------------------
    assign o_rdata = st_r.rdata;
    assign o_rd_hit = st_r.rd_hit;
    assign o_to_pos = st_r.to_pos;
    assign o_to_neg = st_r.to_neg;
    assign o_to_bias = st_r.to_bias;
    assign o_negative_offset_en = st_r.neg_en;
    assign o_positive_offset_en = st_r.pos_en;
    assign o_negative_offset_magnitude = st_r.neg_mag;
    assign o_positive_offset_magnitude = st_r.pos_mag;
    assign o_negative_offset_ff = st_r.neg_ff;
    assign o_positive_offset_ff = st_r.pos_ff;
    assign o_negative_offset_steer = st_r.neg_steer;
    assign o_positive_offset_steer = st_r.pos_steer;
    assign o_negative_threshold_fraction = st_r.neg_thr;
    assign o_positive_threshold_fraction = st_r.pos_thr;
    assign o_negative_peak_level = st_r.neg_pk;
    assign o_positive_peak_level = st_r.pos_pk;
endmodule

// [include/ssc_pkg.sv]
/*
 * Constants for the per-stage sense configuration decode: register map, field positions,
 * routing codes, the percentage table of the threshold fields and the percentage base and step of the peak-detect fields.
 * Assumes the register port delivers word addresses of the device's register space.
 */
package ssc_pkg;

    // ---------------------------------------------------------------
    // register map
    // ---------------------------------------------------------------
    localparam int SSC_ADDR_W = 10;
    localparam int SSC_DATA_W = 16;
    localparam logic [9:0] SSC_STAGE_BASE = 10'h080;
    localparam int SSC_STAGE_STRIDE = 8;
    localparam int SSC_WORDS_PER_STAGE = 4;
    localparam logic [1:0] SSC_OFS_LOWER_ROUTING = 2'h0;
    localparam logic [1:0] SSC_OFS_UPPER_ROUTING = 2'h1;
    localparam logic [1:0] SSC_OFS_OFFSET_CONTROL = 2'h2;
    localparam logic [1:0] SSC_OFS_SENSITIVITY = 2'h3;
    localparam logic [15:0] SSC_RESET_WORD = 16'h0000;

    // ---------------------------------------------------------------
    // field positions
    // ---------------------------------------------------------------
    localparam int SSC_INPUTS_PER_WORD = 7;
    localparam int SSC_NEG_OFF_BIT = 14;
    localparam int SSC_POS_OFF_BIT = 15;
    localparam int SSC_NEG_MAG_LSB = 0;
    localparam int SSC_NEG_STEER_BIT = 7;
    localparam int SSC_POS_MAG_LSB = 8;
    localparam int SSC_POS_STEER_BIT = 15;
    localparam int SSC_NEG_THR_LSB = 0;
    localparam int SSC_NEG_PEAK_LSB = 4;
    localparam int SSC_POS_THR_LSB = 8;
    localparam int SSC_POS_PEAK_LSB = 12;

    // ---------------------------------------------------------------
    // routing codes
    // ---------------------------------------------------------------
    localparam logic [1:0] SSC_ROUTE_OFF = 2'h0;
    localparam logic [1:0] SSC_ROUTE_NEG = 2'h1;
    localparam logic [1:0] SSC_ROUTE_POS = 2'h2;
    localparam logic [1:0] SSC_ROUTE_BIAS = 2'h3;

    // ---------------------------------------------------------------
    // scales in hundredths of a percent or femtofarads, and the top defined peak code
    // ---------------------------------------------------------------
    localparam logic [15:0] SSC_OFFSET_FF_PER_LSB = 16'h00a0;
    localparam logic [15:0] SSC_PEAK_BASE = 16'h0fa0;
    localparam logic [15:0] SSC_PEAK_STEP = 16'h03e8;
    localparam logic [2:0] SSC_PEAK_MAX_CODE = 3'h5;
    localparam logic [15:0][15:0] SSC_THR_TABLE = {
        16'h253c, 16'h2368, 16'h2194, 16'h1fc0, 16'h1dea, 16'h1c16, 16'h1a42, 16'h186b,
        16'h1697, 16'h14c3, 16'h12ef, 16'h111b, 16'h0f44, 16'h0d70, 16'h0b9d, 16'h09c4
    };

endpackage

// [core/ssc_route_dec.sv]
/*
 * Decode of one two-bit sense input routing field into three switch enables.
 * Assumes at most one enable may be high; purely combinational.
 */
module ssc_route_dec (
    input wire logic [1:0] i_code,
    output logic o_to_pos,
    output logic o_to_neg,
    output logic o_to_bias
);
    // ---------------------------------------------------------------
    // code decode
    // ---------------------------------------------------------------
    always_comb
    begin
        o_to_pos = 1'b0;
        o_to_neg = 1'b0;
        o_to_bias = 1'b0;
        case (i_code)
            ssc_pkg::SSC_ROUTE_NEG: o_to_neg = 1'b1; // R1
            ssc_pkg::SSC_ROUTE_POS: o_to_pos = 1'b1; // R1
            ssc_pkg::SSC_ROUTE_BIAS: o_to_bias = 1'b1; // R1
            default: o_to_pos = 1'b0; // R1
        endcase
    end
endmodule

// [sim/ssc_stage_config_monitor.sv]
/* checker for the stage sense configuration decode.
   assumes binding into ssc_stage_config, one clock, synchronous reset. */
module ssc_stage_config_monitor #(
    parameter int STAGES = 12
) (
    input wire logic i_clk,
    input wire logic i_reset,
    input wire logic i_wr_en,
    input wire logic i_rd_en,
    input wire logic [9:0] i_addr,
    input wire logic [15:0] i_wdata,
    input wire logic [3:0] i_stage_sel,
    input wire logic [15:0] o_rdata,
    input wire logic o_rd_hit,
    input wire logic [13:0] o_to_pos,
    input wire logic [13:0] o_to_neg,
    input wire logic [13:0] o_to_bias,
    input wire logic o_negative_offset_en,
    input wire logic o_positive_offset_en,
    input wire logic [6:0] o_negative_offset_magnitude,
    input wire logic [6:0] o_positive_offset_magnitude,
    input wire logic [15:0] o_negative_offset_ff,
    input wire logic o_negative_offset_steer,
    input wire logic o_positive_offset_steer,
    input wire logic [15:0] o_negative_peak_level
);
    timeunit 1ns;
    timeprecision 1ps;
    // ------------------------------------------------------------
    // helpers
    // ------------------------------------------------------------
    logic [15:0] wd_d;
    logic [15:0] wd_dd;
    logic map_a;
    // offsets 4..7 of each stage are holes in the map
    assign map_a = i_addr >= 10'h080 && i_addr < 10'h080 + 10'(8 * STAGES) && !i_addr[2];
    always_ff @(posedge i_clk)
    begin
        wd_d <= i_wdata;
        wd_dd <= wd_d;
    end
    default clocking cb @(posedge i_clk);
    endclocking
    default disable iff (i_reset);
    // write with stage 0 shown, kept one more edge so decode sees it
    sequence s_wr0(logic [9:0] a);
        i_wr_en && i_addr == a && i_stage_sel == 4'h0 ##1 i_stage_sel == 4'h0;
    endsequence
    // ------------------------------------------------------------
    // assertions
    // ------------------------------------------------------------
    a_route_onehot: assert property (
        ((o_to_pos & o_to_neg) | (o_to_pos & o_to_bias) | (o_to_neg & o_to_bias)) == 14'h0)
        else $error("sense input on two destinations");
    a_upper_route: assert property (s_wr0(10'h081) |=> o_to_pos[7] == (wd_dd[1:0] == 2'h2)
        && o_to_bias[7] == (wd_dd[1:0] == 2'h3) && o_to_neg[13] == (wd_dd[13:12] == 2'h1))
        else $error("upper routing decode wrong");
    a_lower_route: assert property (s_wr0(10'h080) |=> o_to_neg[0] == (wd_dd[1:0] == 2'h1)
        && o_to_pos[6] == (wd_dd[13:12] == 2'h2)) else $error("lower routing decode wrong");
    a_offset_gate: assert property (s_wr0(10'h081) |=> o_negative_offset_en == !wd_dd[14]
        && o_positive_offset_en == !wd_dd[15]) else $error("offset gate wrong");
    a_offset_fields: assert property (s_wr0(10'h082) |=>
        o_negative_offset_magnitude == wd_dd[6:0] && o_negative_offset_steer == wd_dd[7]
        && o_positive_offset_magnitude == wd_dd[14:8] && o_positive_offset_steer == wd_dd[15])
        else $error("offset fields wrong");
    a_ff_scale: assert property (
        o_negative_offset_ff == 16'h00a0 * {9'h0, o_negative_offset_magnitude})
        else $error("offset scale wrong");
    a_peak_decode: assert property (s_wr0(10'h083) |=> o_negative_peak_level
        == (wd_dd[6:4] > 3'h5 ? 16'h2328 : 16'h0fa0 + 16'h03e8 * {13'h0, wd_dd[6:4]}))
        else $error("peak level wrong");
    a_read_hit: assert property (i_rd_en && map_a |=> o_rd_hit)
        else $error("mapped read missed");
    a_read_miss: assert property (i_rd_en && !map_a |=> !o_rd_hit && o_rdata == 16'h0)
        else $error("unmapped read answered");
    a_sel_range: assert property (i_stage_sel >= 4'(STAGES) |=> o_to_pos == 14'h0
        && o_to_bias == 14'h0) else $error("absent stage routed");
endmodule

bind ssc_stage_config ssc_stage_config_monitor #(.STAGES(STAGES)) u_mon (.i_clk, .i_reset,
    .i_wr_en, .i_rd_en, .i_addr, .i_wdata, .i_stage_sel, .o_rdata, .o_rd_hit, .o_to_pos,
    .o_to_neg, .o_to_bias, .o_negative_offset_en, .o_positive_offset_en,
    .o_negative_offset_magnitude, .o_positive_offset_magnitude, .o_negative_offset_ff,
    .o_negative_offset_steer, .o_positive_offset_steer, .o_negative_peak_level);

// [sim/ssc_stage_config_tb.sv]
/* self-checking bench for the stage sense configuration decode.
   assumes single-cycle word strobes and registered decode, as the design hands over. */
module ssc_stage_config_tb;
    timeunit 1ns;
    timeprecision 1ps;
    // ------------------------------------------------------------
    // signals
    // ------------------------------------------------------------
    logic i_clk = 1'b0;
    logic i_reset = 1'b1;
    logic i_wr_en = 1'b0;
    logic i_rd_en = 1'b0;
    logic [9:0] i_addr = 10'h000;
    logic [15:0] i_wdata = 16'h0000;
    logic [3:0] i_stage_sel = 4'h0;
    logic o_rd_hit, o_negative_offset_en, o_positive_offset_en;
    logic o_negative_offset_steer, o_positive_offset_steer;
    logic [13:0] o_to_pos, o_to_neg, o_to_bias;
    logic [6:0] o_negative_offset_magnitude, o_positive_offset_magnitude;
    logic [15:0] o_rdata, o_negative_offset_ff, o_positive_offset_ff, o_negative_peak_level;
    logic [15:0] o_negative_threshold_fraction, o_positive_threshold_fraction;
    logic [15:0] o_positive_peak_level;
    int n_errors = 0;
    int num_checks = 0;
    // hundredths of a percent, straight from the level table
    logic [15:0] thr [16] = '{16'h09c4, 16'h0b9d, 16'h0d70, 16'h0f44, 16'h111b, 16'h12ef,
        16'h14c3, 16'h1697, 16'h186b, 16'h1a42, 16'h1c16, 16'h1dea, 16'h1fc0, 16'h2194,
        16'h2368, 16'h253c};
    logic [15:0] ow [3] = '{16'h807f, 16'h7f80, 16'h2a55};
    always #4 i_clk = ~i_clk;
    ssc_stage_config #(.STAGES(12)) u_dut (.i_clk, .i_reset, .i_wr_en, .i_rd_en, .i_addr,
        .i_wdata, .o_rdata, .o_rd_hit, .i_stage_sel, .o_to_pos, .o_to_neg, .o_to_bias,
        .o_negative_offset_en, .o_positive_offset_en, .o_negative_offset_magnitude,
        .o_positive_offset_magnitude, .o_negative_offset_ff, .o_positive_offset_ff,
        .o_negative_offset_steer, .o_positive_offset_steer, .o_negative_threshold_fraction,
        .o_positive_threshold_fraction, .o_negative_peak_level, .o_positive_peak_level);
    // ------------------------------------------------------------
    // tasks
    // ------------------------------------------------------------
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        num_checks++;
        if (got !== exp)
        begin
            n_errors++;
            $display("BAD %0t got %h exp %h", $time, got, exp);
        end
    endtask
    task automatic wr(input logic [9:0] a, input logic [15:0] d);
        @(posedge i_clk);
        i_wr_en <= 1'b1;
        i_addr <= a;
        i_wdata <= d;
        @(posedge i_clk);
        i_wr_en <= 1'b0;
    endtask
    task automatic rd(input logic [9:0] a, input logic [15:0] exp, input logic hit);
        @(posedge i_clk);
        i_rd_en <= 1'b1;
        i_addr <= a;
        @(posedge i_clk);
        i_rd_en <= 1'b0;
        #1;
        chk(o_rdata, exp);
        chk({15'h0, o_rd_hit}, {15'h0, hit});
    endtask
    // decode lags a write by two edges, a select change by one
    task automatic settle(input logic [3:0] s);
        @(posedge i_clk);
        i_stage_sel <= s;
        repeat (2) @(posedge i_clk);
        #1;
    endtask
    task automatic end_of_test;
        $display("checks %0d mismatches %0d", num_checks, n_errors);
        if (n_errors == 0 && num_checks > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask
    // ------------------------------------------------------------
    // tests
    // ------------------------------------------------------------
    initial
    begin
        #20000;
        n_errors++;
        end_of_test();
    end
    initial
    begin
        logic [15:0] lo, up, w;
        logic [13:0] ep, en, eb;
        logic [1:0] c;
        repeat (16) @(posedge i_clk);
        i_reset <= 1'b0;
        settle(4'h0);
        chk(o_negative_threshold_fraction, thr[0]);
        chk(o_positive_peak_level, 16'h0fa0);
        chk({15'h0, o_negative_offset_en}, 16'h0001);
        chk({2'h0, o_to_bias}, 16'h0000);
        rd(10'h080, 16'h0000, 1'b1);
        $display("test reset done");
        for (int k = 0; k < 4; k++)
        begin
            for (int n = 0; n < 14; n++)
            begin
                c = 2'(n + k);
                if (n < 7)
                    lo[2 * n +: 2] = c;
                else
                    up[2 * (n - 7) +: 2] = c;
                ep[n] = c == 2'h2;
                en[n] = c == 2'h1;
                eb[n] = c == 2'h3;
            end
            lo[15:14] = 2'h0;
            up[15:14] = 2'(k);
            wr(10'h080, lo);
            wr(10'h081, up);
            settle(4'h0);
            chk({2'h0, o_to_pos}, {2'h0, ep});
            chk({2'h0, o_to_neg}, {2'h0, en});
            chk({2'h0, o_to_bias}, {2'h0, eb});
            chk({15'h0, o_negative_offset_en}, {15'h0, !up[14]});
            chk({15'h0, o_positive_offset_en}, {15'h0, !up[15]});
            rd(10'h081, up, 1'b1);
        end
        $display("test routing done");
        foreach (ow[i])
        begin
            wr(10'h082, ow[i]);
            settle(4'h0);
            chk({9'h0, o_negative_offset_magnitude}, {9'h0, ow[i][6:0]});
            chk(o_negative_offset_ff, 16'h00a0 * {9'h0, ow[i][6:0]});
            chk({15'h0, o_negative_offset_steer}, {15'h0, ow[i][7]});
            chk(o_positive_offset_ff, 16'h00a0 * {9'h0, ow[i][14:8]});
            chk({9'h0, o_positive_offset_magnitude}, {9'h0, ow[i][14:8]});
            chk({15'h0, o_positive_offset_steer}, {15'h0, ow[i][15]});
        end
        $display("test offset done");
        for (int q = 0; q < 16; q++)
        begin
            w = {1'b0, 3'(q % 6), 4'(15 - q), 1'b0, 3'((q + 3) % 6), 4'(q)};
            wr(10'h083, w);
            settle(4'h0);
            chk(o_negative_threshold_fraction, thr[q]);
            chk(o_positive_threshold_fraction, thr[15 - q]);
            chk(o_negative_peak_level, 16'h0fa0 + 16'h03e8 * 16'((q + 3) % 6));
            chk(o_positive_peak_level, 16'h0fa0 + 16'h03e8 * 16'(q % 6));
        end
        // undefined peak codes hold at the top level
        wr(10'h083, 16'h7060);
        settle(4'h0);
        chk(o_negative_peak_level, 16'h2328);
        chk(o_positive_peak_level, 16'h2328);
        chk(o_negative_threshold_fraction, thr[0]);
        $display("test sensitivity done");
        wr(10'h0d9, 16'h8003);
        settle(4'hb);
        chk({2'h0, o_to_bias}, 16'h0080);
        chk({15'h0, o_positive_offset_en}, 16'h0000);
        rd(10'h0d9, 16'h8003, 1'b1);
        settle(4'h5);
        chk({2'h0, o_to_bias}, 16'h0000);
        settle(4'hc);
        chk({2'h0, o_to_pos}, 16'h0000);
        rd(10'h084, 16'h0000, 1'b0);
        wr(10'h0e0, 16'hffff);
        rd(10'h0e0, 16'h0000, 1'b0);
        @(posedge i_clk);
        i_reset <= 1'b1;
        @(posedge i_clk);
        i_reset <= 1'b0;
        rd(10'h0d9, 16'h0000, 1'b1);
        $display("test stages done");
        end_of_test();
    end
endmodule
